// ==== core/power_mode_controller.sv ====
`timescale 1ns/10ps
`include "pmc_defs.svh"
module power_mode_controller
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output pmc_pkg::axi_resp_t bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output pmc_pkg::axi_resp_t rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic stop_exec,
  input wire logic wait_exec,
  input wire logic irq_pending,
  input wire logic tod_irq,
  input wire logic reset_pin_n,
  input wire logic debug_keepalive_enable,
  input wire logic supply_detect_in_stop_enable,
  output pmc_pkg::pmode_t mode,
  output logic cpu_clk_en,
  output logic [15:0] periph_clk_en,
  output logic debug_clk_en,
  output logic int_ref_run,
  output logic ext_osc_run,
  output logic regulator_full_on,
  output logic regulator_standby,
  output logic regulator_partial_off,
  output logic tod_clk_ok,
  output logic lcd_clk_ok,
  output logic por_req,
  output logic low_power_run_status
);
  import pmc_pkg::*;

  // ****************************************
  // Register file
  // ****************************************
  pmc_regs_if rif ();
  pmode_t mode_q;
  pmode_t mode_d;
  logic low_power_run_status_q;
  logic [3:0] por_cnt_q;
  pmc_axi_regs u_regs
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .rif(rif)
  );
  wire low_power_run_request = rif.ctrl[`PMC_CTRL_LPR_BIT];
  wire wake_to_full_run = rif.ctrl[`PMC_CTRL_WAKE_FULL_BIT];
  wire deep_sel = rif.ctrl[`PMC_CTRL_DEEP_SEL_BIT];
  wire promote = debug_keepalive_enable || supply_detect_in_stop_enable;
  assign rif.status = {24'h0, 2'h0, low_power_run_status_q, por_cnt_q != 4'h0, 1'b0, mode_q};

  // ****************************************
  // Mode sequencer
  // ****************************************
  wire wake_full = !low_power_run_request || wake_to_full_run;
  wire deepest_stop_level_ok = deep_sel && !promote;
  wire lp_ok = low_power_run_request && !promote;
  always_comb
  begin
    mode_d = mode_q;
    case (mode_q)
      MODE_RUN:
      begin
        if (stop_exec)
          mode_d = deepest_stop_level_ok ? MODE_DEEPEST_STOP_LEVEL : MODE_RETENTION_STOP_LEVEL;
        else if (wait_exec)
          mode_d = MODE_WAIT;
        else if (lp_ok)
          mode_d = MODE_LOW_POWER_RUN;
      end
      MODE_LOW_POWER_RUN:
      begin
        if (!lp_ok)
          mode_d = MODE_RUN;
        else if (stop_exec)
          mode_d = MODE_RETENTION_STOP_LEVEL;
        else if (wait_exec)
          mode_d = MODE_LOW_POWER_WAIT;
      end
      MODE_WAIT:
        if (irq_pending)
          mode_d = MODE_RUN;
      MODE_LOW_POWER_WAIT:
        if (irq_pending || !lp_ok)
          mode_d = (wake_full || !lp_ok) ? MODE_RUN : MODE_LOW_POWER_RUN;
      MODE_RETENTION_STOP_LEVEL:
        if (irq_pending)
          mode_d = (wake_full || !lp_ok) ? MODE_RUN : MODE_LOW_POWER_RUN;
      MODE_DEEPEST_STOP_LEVEL:
        if (tod_irq)
          mode_d = MODE_RUN;
      default:
        mode_d = MODE_RUN;
    endcase
  end
  wire pin_wake = mode_q == MODE_DEEPEST_STOP_LEVEL && !reset_pin_n;
  wire irq_full_exit = irq_pending && wake_to_full_run && low_power_run_request
    && (mode_q == MODE_RETENTION_STOP_LEVEL || mode_q == MODE_LOW_POWER_WAIT);
  assign rif.lpr_clr = irq_full_exit;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_q <= MODE_RUN;
      low_power_run_status_q <= 1'b0;
      por_cnt_q <= 4'h0;
    end
    else
    begin
      mode_q <= pin_wake ? MODE_RUN : mode_d;
      // Status survives a stop entered from low power run until the wake
      low_power_run_status_q <= irq_full_exit ? 1'b0
        : (mode_d == MODE_LOW_POWER_RUN || mode_d == MODE_LOW_POWER_WAIT
        || (mode_d == MODE_RETENTION_STOP_LEVEL && low_power_run_status_q));
      if (pin_wake)
        por_cnt_q <= `PMC_POR_CYCLES;
      else if (por_cnt_q != 4'h0)
        por_cnt_q <= por_cnt_q - 4'h1;
    end
  end

  // ****************************************
  // Clock and regulator controls
  // ****************************************
  wire in_stop = mode_q == MODE_DEEPEST_STOP_LEVEL || mode_q == MODE_RETENTION_STOP_LEVEL;
  wire in_lp = mode_q == MODE_LOW_POWER_RUN || mode_q == MODE_LOW_POWER_WAIT;
  wire [15:0] gates = {rif.gate2, rif.gate1};
  logic [15:0] periph_d;
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++)
    begin : g_gate
      assign periph_d[gi] = in_stop ? 1'b0 : (in_lp ? gates[gi] : 1'b1);
    end
  endgenerate
  wire int_ref_d = mode_q != MODE_DEEPEST_STOP_LEVEL && (mode_q != MODE_RETENTION_STOP_LEVEL
    || (rif.ctrl[`PMC_CTRL_INTERNAL_REF_CLOCK_ENABLE_BIT] && rif.ctrl[`PMC_CTRL_INTERNAL_REF_STOP_ENABLE_BIT]));
  wire ext_osc_d = !in_stop
    || (rif.ctrl[`PMC_CTRL_EXTERNAL_REF_CLOCK_ENABLE_BIT] && rif.ctrl[`PMC_CTRL_EXTERNAL_REF_STOP_ENABLE_BIT]);
  wire reg_full_d = (mode_q == MODE_RUN || mode_q == MODE_WAIT)
    || (mode_q == MODE_RETENTION_STOP_LEVEL && supply_detect_in_stop_enable);
  wire tod_ok_d = !in_lp
    || rif.ctrl[`PMC_CTRL_TOD_LPO_BIT] || rif.ctrl[`PMC_CTRL_TOD_OSC_BIT];
  wire lcd_ok_d = !in_lp
    || rif.ctrl[`PMC_CTRL_LCD_OSC_BIT] || rif.ctrl[`PMC_CTRL_LCD_TIME_OF_DAY_CLOCK_BIT];
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode <= MODE_RUN;
      cpu_clk_en <= 1'b1;
      periph_clk_en <= 16'hffff;
      debug_clk_en <= 1'b0;
      int_ref_run <= 1'b1;
      ext_osc_run <= 1'b1;
      regulator_full_on <= 1'b1;
      regulator_standby <= 1'b0;
      regulator_partial_off <= 1'b0;
      tod_clk_ok <= 1'b1;
      lcd_clk_ok <= 1'b1;
      por_req <= 1'b0;
      low_power_run_status <= 1'b0;
    end
    else
    begin
      mode <= mode_q;
      cpu_clk_en <= mode_q == MODE_RUN || mode_q == MODE_LOW_POWER_RUN;
      periph_clk_en <= periph_d;
      debug_clk_en <= debug_keepalive_enable && !in_lp;
      int_ref_run <= int_ref_d;
      ext_osc_run <= ext_osc_d;
      regulator_full_on <= reg_full_d;
      regulator_standby <= !reg_full_d && mode_q != MODE_DEEPEST_STOP_LEVEL;
      regulator_partial_off <= mode_q == MODE_DEEPEST_STOP_LEVEL;
      tod_clk_ok <= tod_ok_d;
      lcd_clk_ok <= lcd_ok_d;
      por_req <= por_cnt_q != 4'h0;
      low_power_run_status <= low_power_run_status_q;
    end
  end
endmodule // power_mode_controller

// ==== core/pmc_defs.svh ====
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH

// Register byte offsets
`define PMC_CTRL_OFS 8'h00
`define PMC_GATE1_OFS 8'h04
`define PMC_GATE2_OFS 8'h08
`define PMC_STATUS_OFS 8'h0c
// Control field positions
`define PMC_CTRL_LPR_BIT 0
`define PMC_CTRL_WAKE_FULL_BIT 1
`define PMC_CTRL_DEEP_SEL_BIT 2
`define PMC_CTRL_INTERNAL_REF_CLOCK_ENABLE_BIT 3
`define PMC_CTRL_INTERNAL_REF_STOP_ENABLE_BIT 4
`define PMC_CTRL_EXTERNAL_REF_CLOCK_ENABLE_BIT 5
`define PMC_CTRL_EXTERNAL_REF_STOP_ENABLE_BIT 6
`define PMC_CTRL_TOD_LPO_BIT 7
`define PMC_CTRL_TOD_OSC_BIT 8
`define PMC_CTRL_LCD_OSC_BIT 9
`define PMC_CTRL_LCD_TIME_OF_DAY_CLOCK_BIT 10
`define PMC_CTRL_WIDTH 11
// Reset values
`define PMC_CTRL_RST 11'h000
`define PMC_GATE_RST 8'hff
// Power-on reset pulse length in cycles
`define PMC_POR_CYCLES 4'h8
`endif

// ==== core/pmc_pkg.sv ====
package pmc_pkg;
  typedef enum logic [2:0] {
    MODE_RUN = 3'h0,
    MODE_WAIT = 3'h1,
    MODE_LOW_POWER_RUN = 3'h3,
    MODE_LOW_POWER_WAIT = 3'h2,
    MODE_RETENTION_STOP_LEVEL = 3'h6,
    MODE_DEEPEST_STOP_LEVEL = 3'h7
  } pmode_t;
  typedef logic [1:0] axi_resp_t;
endpackage

// ==== core/pmc_regs_if.sv ====
`timescale 1ns/10ps
interface pmc_regs_if;
  logic [10:0] ctrl;
  logic [7:0] gate1;
  logic [7:0] gate2;
  logic [31:0] status;
  logic lpr_clr;
  modport regs (output ctrl, output gate1, output gate2, input status, input lpr_clr);
  modport core (input ctrl, input gate1, input gate2, output status, output lpr_clr);
endinterface // pmc_regs_if

// ==== core/pmc_axi_regs.sv ====
`timescale 1ns/10ps
`include "pmc_defs.svh"
module pmc_axi_regs
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  pmc_regs_if.regs rif
);
  logic aw_q;
  logic w_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [10:0] ctrl_q;
  logic [7:0] gate1_q;
  logic [7:0] gate2_q;
  logic [31:0] ctrl_wd;
  wire do_wr = aw_q && w_q && !bvalid;
  wire wr_ctrl = do_wr && awaddr_q == `PMC_CTRL_OFS && wstrb_q[0];
  wire wr_ctrl_hi = do_wr && awaddr_q == `PMC_CTRL_OFS && wstrb_q[1];
  wire wr_g1 = do_wr && awaddr_q == `PMC_GATE1_OFS && wstrb_q[0];
  wire wr_g2 = do_wr && awaddr_q == `PMC_GATE2_OFS && wstrb_q[0];
  wire wr_hit = awaddr_q == `PMC_CTRL_OFS || awaddr_q == `PMC_GATE1_OFS
    || awaddr_q == `PMC_GATE2_OFS || awaddr_q == `PMC_STATUS_OFS;
  wire rd_hit = araddr == `PMC_CTRL_OFS || araddr == `PMC_GATE1_OFS
    || araddr == `PMC_GATE2_OFS || araddr == `PMC_STATUS_OFS;
  wire [31:0] rd_mux = araddr == `PMC_CTRL_OFS ? {21'h0, ctrl_q}
    : araddr == `PMC_GATE1_OFS ? {24'h0, gate1_q}
    : araddr == `PMC_GATE2_OFS ? {24'h0, gate2_q}
    : araddr == `PMC_STATUS_OFS ? rif.status : 32'h0;
  wire [10:0] new_ctrl = {wr_ctrl_hi ? wdata_q[10:8] : ctrl_q[10:8],
    wr_ctrl ? wdata_q[7:0] : ctrl_q[7:0]};
  // Whichever of the exclusive pair is already set keeps the other clear
  // Both asked at once from clear: deep stop wins, so the pair never coexists
  wire keep_deep = ctrl_q[`PMC_CTRL_LPR_BIT] ? 1'b0 : new_ctrl[`PMC_CTRL_DEEP_SEL_BIT];
  wire keep_lpr = !ctrl_q[`PMC_CTRL_DEEP_SEL_BIT] && !keep_deep
    && new_ctrl[`PMC_CTRL_LPR_BIT];
  always_comb
  begin
    ctrl_wd = {21'h0, new_ctrl};
    ctrl_wd[`PMC_CTRL_DEEP_SEL_BIT] = keep_deep;
    ctrl_wd[`PMC_CTRL_LPR_BIT] = keep_lpr && !rif.lpr_clr;
  end
  assign rif.ctrl = ctrl_q;
  assign rif.gate1 = gate1_q;
  assign rif.gate2 = gate2_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= 2'h0;
      ctrl_q <= `PMC_CTRL_RST;
      gate1_q <= `PMC_GATE_RST;
      gate2_q <= `PMC_GATE_RST;
    end
    else
    begin
      awready <= !aw_q && !awready && awvalid;
      wready <= !w_q && !wready && wvalid;
      if (awvalid && awready)
      begin
        aw_q <= 1'b1;
        awaddr_q <= {awaddr[7:2], 2'h0};
      end
      if (wvalid && wready)
      begin
        w_q <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (do_wr)
      begin
        bvalid <= 1'b1;
        bresp <= wr_hit ? 2'h0 : 2'h2;
        aw_q <= 1'b0;
        w_q <= 1'b0;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
      ctrl_q <= ctrl_wd[10:0];
      if (wr_g1)
        gate1_q <= wdata_q[7:0];
      if (wr_g2)
        gate2_q <= wdata_q[7:0];
      arready <= !arready && !rvalid && arvalid;
      if (arvalid && arready)
      begin
        rvalid <= 1'b1;
        rdata <= rd_mux;
        rresp <= rd_hit ? 2'h0 : 2'h2;
      end
      else if (rvalid && rready)
        rvalid <= 1'b0;
    end
  end
endmodule // pmc_axi_regs

// ==== dv/pmc_cpu_model.sv ====
`timescale 1ns/10ps
module pmc_cpu_model
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic go_stop,
  input wire logic go_wait,
  output logic stop_exec,
  output logic wait_exec
);
  // ****
  // Instruction pulses
  // ****
  // Context reload from RAM after deep wake is not modelled
  // Clock generator bypass and slow bus before low power run: software duty
  always_ff @(posedge aclk)
  begin
    stop_exec <= aresetn && go_stop;
    wait_exec <= aresetn && go_wait;
  end
endmodule // pmc_cpu_model

// ==== dv/power_mode_controller_chk.sv ====
`timescale 1ns/10ps
module power_mode_controller_chk
  import pmc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic irq_pending,
  input wire logic tod_irq,
  input wire logic reset_pin_n,
  input wire logic debug_keepalive_enable,
  input wire logic supply_detect_in_stop_enable,
  input pmc_pkg::pmode_t mode,
  input logic [15:0] periph_clk_en,
  input logic debug_clk_en,
  input logic regulator_full_on,
  input logic por_req
);
  // ****
  // Mode checks
  // ****
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_deep_exit: assert property ($fell(mode == MODE_DEEPEST_STOP_LEVEL) |->
    $past(tod_irq) || !$past(reset_pin_n) || $past(tod_irq, 2) || !$past(reset_pin_n, 2))
    else $error("deep stop left without wake cause");
  chk_deep_promo: assert property ($rose(mode == MODE_DEEPEST_STOP_LEVEL) |->
    !$past(debug_keepalive_enable, 2) && !$past(supply_detect_in_stop_enable, 2))
    else $error("deep stop entered while promoted");
  chk_deep_from_run: assert property ($rose(mode == MODE_DEEPEST_STOP_LEVEL) |->
    $past(mode) == MODE_RUN) else $error("deep stop entered not from run");
  chk_lp_promo: assert property ((mode inside {MODE_LOW_POWER_RUN, MODE_LOW_POWER_WAIT}) |->
    !$past(debug_keepalive_enable, 2) && !$past(supply_detect_in_stop_enable, 2))
    else $error("low power mode kept while promoted");
  chk_low_power_wait_entry: assert property ($rose(mode == MODE_LOW_POWER_WAIT) |->
    $past(mode) == MODE_LOW_POWER_RUN) else $error("low power wait not from low power run");
  chk_stop_gated: assert property ((mode inside {MODE_DEEPEST_STOP_LEVEL, MODE_RETENTION_STOP_LEVEL}) |->
    periph_clk_en == 16'h0000) else $error("peripheral clock on in stop");
  chk_debug_stop: assert property (mode == MODE_RETENTION_STOP_LEVEL && $past(debug_keepalive_enable)
    && $past(debug_keepalive_enable, 2) |-> debug_clk_en) else $error("debug clock off");
  chk_reg_retention_stop_level: assert property (mode == MODE_RETENTION_STOP_LEVEL && !debug_keepalive_enable &&
    $stable(supply_detect_in_stop_enable) |-> regulator_full_on == supply_detect_in_stop_enable)
    else $error("regulator state wrong in retention stop");
  chk_irq_wake: assert property ((mode inside {MODE_RETENTION_STOP_LEVEL, MODE_WAIT, MODE_LOW_POWER_WAIT}) &&
    irq_pending |-> ##[1:4] !(mode inside {MODE_RETENTION_STOP_LEVEL, MODE_WAIT, MODE_LOW_POWER_WAIT}))
    else $error("interrupt did not wake");
  chk_por_len: assert property ($rose(por_req) |-> por_req[*8] ##1 !por_req)
    else $error("power-on pulse length wrong");
  cov_deep: cover property ($rose(mode == MODE_DEEPEST_STOP_LEVEL));
  cov_ret: cover property ($rose(mode == MODE_RETENTION_STOP_LEVEL));
  cov_low_power_wait: cover property ($rose(mode == MODE_LOW_POWER_WAIT));
endmodule // power_mode_controller_chk

bind power_mode_controller power_mode_controller_chk chk_inst (.aclk, .aresetn,
  .irq_pending, .tod_irq, .reset_pin_n, .debug_keepalive_enable,
  .supply_detect_in_stop_enable, .mode, .periph_clk_en, .debug_clk_en,
  .regulator_full_on, .por_req);

// ==== dv/power_mode_controller_test.sv ====
`timescale 1ns/10ps
module power_mode_controller_test;
  import pmc_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rnd = 32'h0000f3b8, rd, g;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, stop_exec, wait_exec;
  logic go_stop = 0, go_wait = 0, irq_pending = 0, tod_irq = 0, reset_pin_n = 1;
  logic debug_keepalive_enable = 0, supply_detect_in_stop_enable = 0;
  logic cpu_clk_en, debug_clk_en, por_req, low_power_run_status, regulator_full_on;
  logic int_ref_run, ext_osc_run, regulator_standby, regulator_partial_off;
  logic tod_clk_ok, lcd_clk_ok;
  logic [15:0] periph_clk_en;
  axi_resp_t bresp, rresp, rs;
  pmode_t mode;
  int num_errors = 0, checks = 0, i, n, k;
  always #2 aclk = ~aclk;
  power_mode_controller power_mode_controller_inst (.aclk, .aresetn, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .stop_exec, .wait_exec,
    .irq_pending, .tod_irq, .reset_pin_n, .debug_keepalive_enable,
    .supply_detect_in_stop_enable, .mode, .cpu_clk_en, .periph_clk_en, .debug_clk_en,
    .int_ref_run, .ext_osc_run, .regulator_full_on, .regulator_standby,
    .regulator_partial_off, .tod_clk_ok, .lcd_clk_ok, .por_req,
    .low_power_run_status);
  pmc_cpu_model pmc_cpu_model_inst (.aclk, .aresetn, .go_stop, .go_wait, .stop_exec,
    .wait_exec);
  // ****
  // Helpers
  // ****
  function automatic logic [31:0] xs();
    rnd = rnd ^ (rnd << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
    return rnd;
  endfunction
  task automatic close_out();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic want(input pmode_t m);
    @(negedge aclk);
    for (n = 0; n < 30 && mode !== m; n++) @(negedge aclk);
    cmp(mode, m);
    if (mode !== m) close_out();
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (i = 0; i < 40 && bvalid !== 1'b1; i++)
    begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 0;
      if (wready === 1'b1) wvalid <= 0;
    end
    bready <= 0;
    if (bvalid !== 1'b1)
    begin
      cmp(bvalid, 1'b1);
      close_out();
    end
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (i = 0; i < 40 && rvalid !== 1'b1; i++)
    begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 0;
    end
    rd = rdata;
    rs = rresp;
    rready <= 0;
    if (rvalid !== 1'b1)
    begin
      cmp(rvalid, 1'b1);
      close_out();
    end
  endtask
  task automatic ins(input logic s);
    @(posedge aclk);
    go_stop <= s;
    go_wait <= !s;
    @(posedge aclk);
    go_stop <= 0;
    go_wait <= 0;
  endtask
  task automatic irq(input pmode_t m);
    repeat ((xs() % 4) + 1) @(posedge aclk);
    irq_pending <= 1;
    want(m);
    @(posedge aclk) irq_pending <= 0;
  endtask
  // ****
  // Scenarios
  // ****
  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    @(negedge aclk);
    cmp(mode, MODE_RUN);
    cmp(periph_clk_en, 16'hffff);
    cmp(cpu_clk_en, 1'b1);
    axr(8'h10);
    cmp(rs, 2'h2);
    g = xs();
    axw(8'h04, {24'h0, g[7:0]});
    axw(8'h08, {24'h0, g[15:8]});
    axw(8'h00, 32'h1);
    want(MODE_LOW_POWER_RUN);
    cmp(periph_clk_en, g[15:0]);
    cmp(tod_clk_ok, 1'b0);
    cmp(lcd_clk_ok, 1'b0);
    axr(8'h0c);
    cmp(rd[5:0], 6'h23);
    axw(8'h00, 32'h285);
    axr(8'h00);
    cmp(rd[2], 1'b0);
    ins(0);
    want(MODE_LOW_POWER_WAIT);
    cmp(periph_clk_en, g[15:0]);
    cmp(cpu_clk_en, 1'b0);
    cmp(tod_clk_ok, 1'b1);
    cmp(lcd_clk_ok, 1'b1);
    irq(MODE_LOW_POWER_RUN);
    ins(1);
    want(MODE_RETENTION_STOP_LEVEL);
    cmp(regulator_full_on, 1'b0);
    cmp(regulator_standby, 1'b1);
    cmp(int_ref_run, 1'b0);
    cmp(ext_osc_run, 1'b0);
    cmp(low_power_run_status, 1'b1);
    irq(MODE_LOW_POWER_RUN);
    axw(8'h00, 32'h3);
    ins(1);
    want(MODE_RETENTION_STOP_LEVEL);
    irq(MODE_RUN);
    axr(8'h00);
    cmp(rd[0], 1'b0);
    cmp(low_power_run_status, 1'b0);
    axw(8'h00, 32'h64);
    ins(1);
    want(MODE_DEEPEST_STOP_LEVEL);
    cmp(ext_osc_run, 1'b1);
    cmp(int_ref_run, 1'b0);
    cmp(regulator_partial_off, 1'b1);
    @(posedge aclk);
    irq_pending <= 1;
    repeat (10) @(negedge aclk);
    cmp(mode, MODE_DEEPEST_STOP_LEVEL);
    @(posedge aclk);
    irq_pending <= 0;
    tod_irq <= 1;
    want(MODE_RUN);
    @(posedge aclk) tod_irq <= 0;
    ins(1);
    want(MODE_DEEPEST_STOP_LEVEL);
    @(posedge aclk);
    reset_pin_n <= 0;
    k = 0;
    for (i = 0; i < 20; i++)
    begin
      @(negedge aclk);
      if (por_req === 1'b1) k++;
    end
    cmp(mode, MODE_RUN);
    cmp(k, 8);
    @(posedge aclk) reset_pin_n <= 1;
    for (k = 0; k < 2; k++)
    begin
      debug_keepalive_enable <= (k == 0);
      supply_detect_in_stop_enable <= (k == 1);
      axw(8'h00, 32'h1c);
      ins(1);
      want(MODE_RETENTION_STOP_LEVEL);
      cmp(periph_clk_en, 16'h0000);
      cmp(debug_clk_en, !k);
      cmp(int_ref_run, 1'b1);
      if (k) cmp(regulator_full_on, 1'b1);
      irq(MODE_RUN);
      axw(8'h00, 32'h0);
      axw(8'h00, 32'h1);
      repeat (5) @(negedge aclk);
      cmp(mode, MODE_RUN);
      ins(0);
      want(MODE_WAIT);
      irq(MODE_RUN);
      axw(8'h00, 32'h0);
    end
    supply_detect_in_stop_enable <= 0;
    axw(8'h00, 32'h1);
    want(MODE_LOW_POWER_RUN);
    ins(1);
    want(MODE_RETENTION_STOP_LEVEL);
    // ****
    // Reset in mid-run from retention stop
    // ****
    @(posedge aclk);
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    @(negedge aclk);
    cmp(mode, MODE_RUN);
    cmp(low_power_run_status, 1'b0);
    axw(8'h00, 32'h5);
    axr(8'h00);
    cmp(rd[0] & rd[2], 1'b0);
    close_out();
  end
endmodule // power_mode_controller_test
